// >>> verilog/occ_top.sv
// Oscillator on-time control, low-clock forwarding and calibration.
// Assumes APB on core_clk_in, a free-running low clock from its pad,
// and a measuring unit that pulses meas_done_in on the core clock.
//
// Our own choices: the APB slave port and the address map.
module occ_top #(
	parameter int unsigned SET2_CYC = occ_pkg::CYC_SET2,
	parameter int unsigned SET3_CYC = occ_pkg::CYC_SET3,
	parameter int unsigned SET4_CYC = occ_pkg::CYC_SET4,
	parameter int unsigned SET5_CYC = occ_pkg::CYC_SET5,
	parameter logic [15:0] HS_RATIO = 16'(occ_pkg::HS_RATIO_Q16)
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic lowfreq_clk_in,
	input wire logic meas_done_in,
	output logic meas_start_out,
	output logic hs_osc_en_out,
	output logic fire_pin_o_out,
	output logic fire_pin_oe_n_out,
	output logic en_start_o_out,
	output logic en_start_oe_n_out,
	output logic irq_out
);
	occ_pkg::occ_state_t st_r; // Controller state
	occ_pkg::occ_state_t st_nxt; // Next state
	logic [31:0] ctrl_r; // Control register
	occ_pkg::occ_cfg_t cfg; // Decoded control fields
	logic [occ_pkg::ST_W-1:0] stat_r; // Sticky event bits
	logic [occ_pkg::ST_W-1:0] mask_r; // Interrupt enables
	logic [occ_pkg::ST_W-1:0] ev_set; // Events this cycle
	logic [occ_pkg::ST_W-1:0] ev_clr; // Write-one-to-clear bits
	logic [31:0] res_r; // Calibration result
	logic [15:0] cnt_r; // Settling down-counter
	logic is_cal_r; // Pending job is a calibration
	logic [15:0] ccnt_r; // Core cycles in calibration window
	logic [4:0] edges_r; // Low-clock rises seen in window
	logic lf_s1, lf_s2, lf_s3; // Low-clock synchroniser
	logic lf_rise; // Rising edge of low clock
	logic [2:0] div_r; // Divide-by-eight counter
	logic acc; // APB access phase completes
	logic wr; // Register write strobe
	logic cmd_go; // Accepted opcode write
	logic cmd_cal; // Opcode is calibration
	logic cmd_meas; // Opcode is a measurement start

	// Settling cycles for an on-time value; 5 to 7 share the longest
	function automatic logic [15:0] settle_cyc(input logic [2:0] ont);
		if (ont == 3'h2) begin
			return 16'(SET2_CYC);
		end else if (ont == 3'h3) begin
			return 16'(SET3_CYC);
		end else if (ont == 3'h4) begin
			return 16'(SET4_CYC);
		end else begin
			return 16'(SET5_CYC);
		end
	endfunction

	// Window length in low-clock periods: 2, 4, 8 or 16
	function automatic logic [4:0] cal_len(input logic [1:0] sel);
		return 5'(5'h02 << sel);
	endfunction

	// Result in 16.16 fast-clock periods from a core-cycle count
	function automatic logic [31:0] to_q16(input logic [15:0] cyc);
		return cyc * HS_RATIO;
	endfunction

	assign cfg = occ_pkg::occ_cfg_t'({
		ctrl_r[occ_pkg::CALP_LSB +: 2],
		ctrl_r[occ_pkg::SELB_LSB +: 3],
		ctrl_r[occ_pkg::SELA_LSB +: 3],
		ctrl_r[occ_pkg::ONT_LSB +: 3]});

	// Bus strobes; access always completes with no wait state
	assign acc = psel_in && penable_in && pready_out;
	assign wr = acc && pwrite_in;
	assign cmd_cal = pwdata_in[7:0] == occ_pkg::CMD_CAL;
	assign cmd_meas = pwdata_in[7:0] == occ_pkg::CMD_TOF ||
		pwdata_in[7:0] == occ_pkg::CMD_TOF_RPT ||
		pwdata_in[7:0] == occ_pkg::CMD_TEMP ||
		pwdata_in[7:0] == occ_pkg::CMD_TEMP_RPT;
	// Opcodes while busy are dropped so a running job never restarts
	assign cmd_go = wr && paddr_in == occ_pkg::OFF_CMD &&
		st_r == occ_pkg::OCC_IDLE && (cmd_cal || cmd_meas);
	assign lf_rise = lf_s2 && !lf_s3;

	// Low clock sync; halted while ce_in is low or rst_in is high
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lf_s1 <= 1'b0;
			lf_s2 <= 1'b0;
			lf_s3 <= 1'b0;
		end else if (ce_in) begin
			lf_s1 <= lowfreq_clk_in;
			lf_s2 <= lf_s1;
			lf_s3 <= lf_s2;
		end
	end

	// APB answer registered in the setup cycle
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end else if (ce_in) begin
			pready_out <= psel_in && !penable_in;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			if (psel_in && !penable_in) begin
				if (paddr_in == occ_pkg::OFF_CTRL) begin
					prdata_out <= ctrl_r;
				end else if (paddr_in == occ_pkg::OFF_CMD) begin
					prdata_out <= 32'h0000_0000;
				end else if (paddr_in == occ_pkg::OFF_STAT) begin
					prdata_out <= 32'(stat_r);
				end else if (paddr_in == occ_pkg::OFF_MASK) begin
					prdata_out <= 32'(mask_r);
				end else if (paddr_in == occ_pkg::OFF_RES) begin
					prdata_out <= res_r;
				end else if (paddr_in == occ_pkg::OFF_STATE) begin
					prdata_out <= {28'h000_0000, hs_osc_en_out, 3'(st_r)};
				end else begin
					pslverr_out <= 1'b1; // Unmapped address
				end
			end
		end
	end

	// Control and mask registers
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_r <= occ_pkg::CTRL_RST;
			mask_r <= '0;
		end else if (ce_in && wr) begin
			if (paddr_in == occ_pkg::OFF_CTRL) begin
				ctrl_r <= pwdata_in;
			end else if (paddr_in == occ_pkg::OFF_MASK) begin
				mask_r <= pwdata_in[occ_pkg::ST_W-1:0];
			end
		end
	end

	// Next state of the measurement and calibration sequencer
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			occ_pkg::OCC_IDLE: begin
				if (cmd_go && cfg.hs_osc_on_time > occ_pkg::ONT_CONT) begin
					st_nxt = occ_pkg::OCC_SETTLE;
				end else if (cmd_go && cmd_cal) begin
					st_nxt = occ_pkg::OCC_CSYNC;
				end else if (cmd_go) begin
					st_nxt = occ_pkg::OCC_MEAS;
				end
			end
			occ_pkg::OCC_SETTLE: begin
				if (cnt_r == 16'h0001) begin
					st_nxt = is_cal_r ? occ_pkg::OCC_CSYNC : occ_pkg::OCC_MEAS;
				end
			end
			occ_pkg::OCC_MEAS: begin
				if (meas_done_in) begin
					st_nxt = occ_pkg::OCC_IDLE;
				end
			end
			occ_pkg::OCC_CSYNC: begin
				if (lf_rise) begin
					st_nxt = occ_pkg::OCC_CRUN;
				end
			end
			occ_pkg::OCC_CRUN: begin
				if (lf_rise && edges_r + 5'h01 == cal_len(cfg.cal_period_count)) begin
					st_nxt = occ_pkg::OCC_CSTORE;
				end
			end
			default: begin
				st_nxt = occ_pkg::OCC_IDLE;
			end
		endcase
	end

	// State register and job kind
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= occ_pkg::OCC_IDLE;
			is_cal_r <= 1'b0;
		end else if (ce_in) begin
			st_r <= st_nxt;
			if (cmd_go) begin
				is_cal_r <= cmd_cal;
			end
		end
	end

	// Settling counter holds the measurement back while osc settles
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= 16'h0000;
		end else if (ce_in) begin
			if (cmd_go) begin
				cnt_r <= settle_cyc(cfg.hs_osc_on_time);
			end else if (st_r == occ_pkg::OCC_SETTLE) begin
				cnt_r <= cnt_r - 16'h0001;
			end
		end
	end

	// Oscillator enable follows the next state so settling starts now
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hs_osc_en_out <= 1'b0;
		end else if (ce_in) begin
			if (cfg.hs_osc_on_time == occ_pkg::ONT_OFF) begin
				hs_osc_en_out <= 1'b0;
			end else if (cfg.hs_osc_on_time == occ_pkg::ONT_CONT) begin
				hs_osc_en_out <= 1'b1;
			end else begin
				// Fast clock also runs through the calibration states
				hs_osc_en_out <= st_nxt != occ_pkg::OCC_IDLE;
			end
		end
	end

	// One-cycle start pulse to the measuring unit
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			meas_start_out <= 1'b0;
		end else if (ce_in) begin
			meas_start_out <= st_nxt == occ_pkg::OCC_MEAS &&
				st_r != occ_pkg::OCC_MEAS;
		end
	end

	// Calibration window: counts core cycles between low-clock rises
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ccnt_r <= 16'h0000;
			edges_r <= 5'h00;
			res_r <= 32'h0000_0000;
		end else if (ce_in) begin
			if (st_r == occ_pkg::OCC_CSYNC) begin
				ccnt_r <= 16'h0000;
				edges_r <= 5'h00;
			end else if (st_r == occ_pkg::OCC_CRUN) begin
				ccnt_r <= ccnt_r + 16'h0001;
				if (lf_rise) begin
					edges_r <= edges_r + 5'h01;
				end
				// Result lands a cycle before its flag
				if (st_nxt == occ_pkg::OCC_CSTORE) begin
					res_r <= to_q16(ccnt_r + 16'h0001);
				end
			end
		end
	end

	// Event sources for the status register
	always_comb begin
		ev_set = '0;
		ev_set[occ_pkg::ST_MEAS] = st_r == occ_pkg::OCC_MEAS &&
			meas_done_in;
		ev_set[occ_pkg::ST_CAL] = st_r == occ_pkg::OCC_CSTORE;
		ev_clr = '0;
		if (wr && paddr_in == occ_pkg::OFF_STAT) begin
			ev_clr = pwdata_in[occ_pkg::ST_W-1:0];
		end
	end

	// Sticky status; a set in the clearing cycle survives
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stat_r <= '0;
			irq_out <= 1'b0;
		end else if (ce_in) begin
			stat_r <= (stat_r & ~ev_clr) | ev_set;
			irq_out <= |(((stat_r & ~ev_clr) | ev_set) & mask_r);
		end
	end

	// Low clock forwarded to the pins; idle pins stay released
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_r <= 3'h0;
			fire_pin_o_out <= 1'b0;
			fire_pin_oe_n_out <= 1'b1;
			en_start_o_out <= 1'b0;
			en_start_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			fire_pin_o_out <= lf_s2;
			fire_pin_oe_n_out <= cfg.test_out_sel_a != occ_pkg::SEL_LF;
			en_start_oe_n_out <= cfg.test_out_sel_b != occ_pkg::SEL_LF;
			if (lf_rise) begin
				div_r <= div_r + 3'h1;
				en_start_o_out <= div_r[1] & div_r[0] ^ div_r[2];
			end
		end
	end

	// Helper: cycles spent in the settling state
	logic [15:0] hlp_set_r;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hlp_set_r <= 16'h0000;
		end else if (ce_in) begin
			hlp_set_r <= st_r == occ_pkg::OCC_SETTLE ?
				hlp_set_r + 16'h0001 : 16'h0000;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in || !ce_in);

	chk_osc_held_off: assert property (
		cfg.hs_osc_on_time == occ_pkg::ONT_OFF |=> !hs_osc_en_out)
		else $error("oscillator on while on-time is zero");
	chk_osc_cont_on: assert property (
		cfg.hs_osc_on_time == occ_pkg::ONT_CONT |=> hs_osc_en_out)
		else $error("oscillator off while on-time is one");
	chk_osc_per_job: assert property (
		cfg.hs_osc_on_time > occ_pkg::ONT_CONT && st_r == occ_pkg::OCC_IDLE
		&& !cmd_go |=> !hs_osc_en_out)
		else $error("oscillator on outside a measurement");
	chk_settle_len: assert property (
		st_r == occ_pkg::OCC_SETTLE && st_nxt != occ_pkg::OCC_SETTLE
		|-> hlp_set_r + 16'h0001 == settle_cyc(cfg.hs_osc_on_time))
		else $error("settling delay length wrong");
	chk_start_osc_on: assert property (
		meas_start_out && cfg.hs_osc_on_time > occ_pkg::ONT_CONT
		|-> hs_osc_en_out)
		else $error("measurement started with oscillator off");
	chk_fire_pin_drive: assert property (
		cfg.test_out_sel_a == occ_pkg::SEL_LF |=>
		!fire_pin_oe_n_out && fire_pin_o_out == $past(lf_s2))
		else $error("low clock not on fire pin");
	chk_div_steady: assert property (
		!lf_rise |=> $stable(en_start_o_out))
		else $error("divided clock moved without low-clock edge");
	chk_cal_window: assert property (
		st_r == occ_pkg::OCC_CSTORE |-> $past(st_r) == occ_pkg::OCC_CRUN
		&& $past(edges_r) + 5'h01 == cal_len(cfg.cal_period_count))
		else $error("calibration window period count wrong");
	chk_cal_result: assert property (
		st_r == occ_pkg::OCC_CSTORE |->
		res_r == to_q16($past(ccnt_r) + 16'h0001))
		else $error("calibration result not stored");
	chk_cal_flag: assert property (
		st_r == occ_pkg::OCC_CRUN ##1 st_r == occ_pkg::OCC_CSTORE
		|=> stat_r[occ_pkg::ST_CAL] && $stable(res_r))
		else $error("calibration flag missing after result");
	chk_meas_flag: assert property (
		st_r == occ_pkg::OCC_MEAS && meas_done_in |=>
		stat_r[occ_pkg::ST_MEAS] && st_r == occ_pkg::OCC_IDLE)
		else $error("measurement flag missing");

	cov_meas_done: cover property (stat_r[occ_pkg::ST_MEAS] && irq_out);
	cov_cal_done: cover property (st_r == occ_pkg::OCC_CSTORE);
	cov_settle_exit: cover property (
		st_r == occ_pkg::OCC_SETTLE ##1 st_r == occ_pkg::OCC_MEAS);
	cov_div_out: cover property (!en_start_oe_n_out && lf_rise);
endmodule

// >>> verilog/occ_pkg.sv
// Constants, types and field layout of the oscillator control block.
// Assumes a 10 MHz core clock and an APB master with 32-bit data.
// Overview of operation
// - On-time 0 keeps oscillator off; 1 continuous
// - On-time above 1: oscillator on per measurement
// - Settling delay per on-time before measurement start
// - High-speed clock serves calibration and measurement
// - Low-power clock always runs, never stoppable; here ce_in low halts its sync and pin forwarding
// - Select A 7 drives low clock on fire pin
// - Select B 7 drives low clock/8 on start pin
// - Calibration times low-clock interval with counter
// - Calibration stores result, then raises flag
// - Calibration period count from bits 23:22
// - Finished measurement raises interrupt flag
package occ_pkg;
	// Core clock period in ns
	localparam int unsigned CLK_NS = 100;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0C;
	localparam logic [7:0] OFF_RES = 8'h10;
	localparam logic [7:0] OFF_STATE = 8'h14;
	// Control field positions
	localparam int ONT_LSB = 0;
	localparam int SELA_LSB = 4;
	localparam int SELB_LSB = 8;
	localparam int CALP_LSB = 22;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Opcodes written to the command register
	localparam logic [7:0] CMD_TOF = 8'h01;
	localparam logic [7:0] CMD_TOF_RPT = 8'h02;
	localparam logic [7:0] CMD_TEMP = 8'h03;
	localparam logic [7:0] CMD_TEMP_RPT = 8'h04;
	localparam logic [7:0] CMD_CAL = 8'h05;
	// Status bits
	localparam int ST_MEAS = 0;
	localparam int ST_CAL = 1;
	localparam int ST_W = 2;
	// Field values
	localparam logic [2:0] ONT_OFF = 3'h0;
	localparam logic [2:0] ONT_CONT = 3'h1;
	localparam logic [2:0] SEL_LF = 3'h7;
	// Settling times in ns and derived cycle counts, rounded up
	localparam int unsigned T_SET2_NS = 480000;
	localparam int unsigned T_SET3_NS = 1460000;
	localparam int unsigned T_SET4_NS = 2440000;
	localparam int unsigned T_SET5_NS = 5140000;
	localparam int unsigned CYC_SET2 = (T_SET2_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_SET3 = (T_SET3_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_SET4 = (T_SET4_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_SET5 = (T_SET5_NS + CLK_NS - 1) / CLK_NS;
	// Fast periods per core cycle in 16.16 (4 MHz over 10 MHz)
	localparam int unsigned HS_RATIO_Q16 = 26214;
	// Controller states
	typedef enum logic [2:0] {
		OCC_IDLE, OCC_SETTLE, OCC_MEAS, OCC_CSYNC, OCC_CRUN, OCC_CSTORE
	} occ_state_t;
	// Decoded control register
	typedef struct packed {
		logic [1:0] cal_period_count;
		logic [2:0] test_out_sel_b;
		logic [2:0] test_out_sel_a;
		logic [2:0] hs_osc_on_time;
	} occ_cfg_t;
endpackage

// >>> testbench/occ_far_model.sv
// Far-side model: the measuring unit that answers start pulses, and
// the host-made low-frequency clock. Assumes the bench core clock.
module occ_far_model (
	input wire logic clk_in,
	input wire logic start_in,
	input wire logic [3:0] delay_in,
	output logic done_out,
	output logic lowfreq_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Rectangular low clock supplied by the host, never stopped;
	// free running, phase unrelated to the core clock
	initial begin
		lowfreq_out = 1'b0;
		forever #15259 lowfreq_out = ~lowfreq_out;
	end

	// Start input is sampled on every core clock edge except while an answer is pending
	initial begin
		done_out = 1'b0;
		forever begin
			@(posedge clk_in);
			// Answer each start after a programmable delay
			if (start_in === 1'b1) begin
				repeat (delay_in) @(posedge clk_in);
				done_out <= 1'b1;
				@(posedge clk_in);
				done_out <= 1'b0;
			end
		end
	end
endmodule

// >>> testbench/tb_osc_control_and_clock_cal.sv
// Self-checking bench for the oscillator control block.
// Assumes occ_pkg, occ_top and occ_far_model are compiled first.
module tb_osc_control_and_clock_cal;
	timeunit 1ns;
	timeprecision 1ns;

	logic core_clk_in, rst_in, ce_in, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, er, lowfreq, meas_done, meas_start, hs_osc_en;
	logic fire_o, fire_oe_n, en_o, en_oe_n, irq;
	logic [3:0] delay;
	int err_count, compares, starts, fire_rises, en_rises, lf_rises;

	// Short settle counts keep the run brief
	occ_top #(.SET2_CYC(4), .SET3_CYC(6), .SET4_CYC(8), .SET5_CYC(10)) dut (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.lowfreq_clk_in(lowfreq), .meas_done_in(meas_done),
		.meas_start_out(meas_start), .hs_osc_en_out(hs_osc_en),
		.fire_pin_o_out(fire_o), .fire_pin_oe_n_out(fire_oe_n),
		.en_start_o_out(en_o), .en_start_oe_n_out(en_oe_n), .irq_out(irq));

	occ_far_model far (.clk_in(core_clk_in), .start_in(meas_start),
		.delay_in(delay), .done_out(meas_done), .lowfreq_out(lowfreq));

	// 10 MHz core clock
	always #50 core_clk_in = ~core_clk_in;
	// Edge counters for pulse and clock checks
	always @(posedge core_clk_in) if (meas_start === 1'b1) starts++;
	always @(posedge fire_o) fire_rises++;
	always @(posedge en_o) en_rises++;
	always @(posedge lowfreq) lf_rises++;

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One APB transfer; waits for pready, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_in);
		penable <= 1'b1;
		// Request holds until pready is sampled high
		do begin
			@(posedge core_clk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Settle cycles expected for each on-time value
	function automatic int settle_cyc(input logic [2:0] t);
		case (t)
			3'h2: return 4;
			3'h3: return 6;
			3'h4: return 8;
			default: return 10;
		endcase
	endfunction

	// One measurement; k is the cycle count from command to start
	task automatic run_meas(input logic [2:0] t, input logic [7:0] op,
		output int k);
		int n;
		delay <= 4'(1 + $urandom % 8);
		apb(1'b1, occ_pkg::OFF_CTRL, {29'h0, t});
		apb(1'b1, occ_pkg::OFF_MASK, 32'h0000_0003);
		apb(1'b1, occ_pkg::OFF_CMD, {24'h0, op});
		n = 0;
		do begin
			@(posedge core_clk_in);
			n++;
			if (n == 1) check("osc_on", hs_osc_en, t != 3'h0);
		end while (meas_start !== 1'b1 && n < 200);
		k = n;
		repeat (12) @(posedge core_clk_in);
		check("osc_after", hs_osc_en, t == 3'h1);
		apb(1'b0, occ_pkg::OFF_STAT, 32'h0);
		check("meas_done", rd, 32'h0000_0001);
		check("irq_set", irq, 1'b1);
		apb(1'b1, occ_pkg::OFF_STAT, 32'h0000_0001);
		@(posedge core_clk_in);
		check("irq_clr", irq, 1'b0);
	endtask

	// Bounded hang guard, well past the expected run length
	initial begin
		repeat (60000) @(posedge core_clk_in);
		err_count++;
		report_and_stop();
	end

	initial begin
		int k0, k, r, c, q, s0;
		logic [7:0] ops[4];
		logic [31:0] v;
		ops = '{occ_pkg::CMD_TOF, occ_pkg::CMD_TOF_RPT,
			occ_pkg::CMD_TEMP, occ_pkg::CMD_TEMP_RPT};
		core_clk_in = 1'b0;
		rst_in = 1'b1;
		ce_in = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		delay = 4'h1;
		r = $urandom(19323);
		repeat (10) @(posedge core_clk_in);
		rst_in <= 1'b0;
		@(posedge core_clk_in);
		check("osc_rst", hs_osc_en, 1'b0);
		check("fire_oe_rst", fire_oe_n, 1'b1);
		check("en_oe_rst", en_oe_n, 1'b1);
		apb(1'b0, occ_pkg::OFF_CTRL, 32'h0);
		check("ctrl_rst", rd, occ_pkg::CTRL_RST);
		$display("test reset done");

		// Static on-times, then every settle value with all opcodes
		run_meas(3'h1, occ_pkg::CMD_TOF, k0);
		run_meas(3'h0, occ_pkg::CMD_TOF, k0);
		check("start_lat", k0 == 1 || k0 == 2, 1'b1);
		r = $urandom % 4;
		for (int t = 2; t < 8; t++) begin
			run_meas(3'(t), ops[(t - 2 + r) % 4], k);
			check("settle", k, k0 + settle_cyc(3'(t)));
		end
		$display("test on-time done");

		// Command while busy and unknown opcode are both ignored
		s0 = starts;
		apb(1'b1, occ_pkg::OFF_CMD, {24'h0, occ_pkg::CMD_TEMP});
		apb(1'b1, occ_pkg::OFF_CMD, {24'h0, occ_pkg::CMD_TOF});
		repeat (40) @(posedge core_clk_in);
		apb(1'b1, occ_pkg::OFF_CMD, 32'h0000_003C);
		repeat (20) @(posedge core_clk_in);
		check("one_start", starts - s0, 1);
		apb(1'b0, occ_pkg::OFF_STATE, 32'h0);
		check("idle", rd[2:0], 3'h0);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped_data", rd, 32'h0000_0000);
		check("unmapped_err", {31'h0000_0000, er}, 32'h0000_0001);
		// Clock enable low freezes a pending settle, then it resumes
		s0 = starts;
		apb(1'b1, occ_pkg::OFF_CMD, {24'h0, occ_pkg::CMD_TOF});
		ce_in <= 1'b0;
		repeat (30) @(posedge core_clk_in);
		check("ce_hold", starts - s0, 0);
		check("ce_osc", hs_osc_en, 1'b1);
		ce_in <= 1'b1;
		repeat (40) @(posedge core_clk_in);
		check("ce_run", starts - s0, 1);
		apb(1'b1, occ_pkg::OFF_STAT, 32'h0000_0003);
		$display("test refusal done");

		// Forward the low clock and its eighth on the two pins
		v = ($urandom & 32'hFF00_0000) | 32'h0000_0770;
		apb(1'b1, occ_pkg::OFF_CTRL, v);
		apb(1'b0, occ_pkg::OFF_CTRL, 32'h0);
		check("ctrl_rb", rd, v);
		check("fire_oe", fire_oe_n, 1'b0);
		check("en_oe", en_oe_n, 1'b0);
		fire_rises = 0;
		en_rises = 0;
		lf_rises = 0;
		repeat (9760) @(posedge core_clk_in);
		check("fire_rate", fire_rises >= lf_rises - 1
			&& fire_rises <= lf_rises + 1, 1'b1);
		check("en_rate", en_rises >= lf_rises / 8 - 1
			&& en_rises <= lf_rises / 8 + 1, 1'b1);
		$display("test low clock done");

		// Calibration over a random period count with on-time 2
		c = $urandom % 4;
		apb(1'b1, occ_pkg::OFF_CTRL, (32'(c) << 22) | 32'h2);
		apb(1'b1, occ_pkg::OFF_MASK, 32'h0000_0002);
		apb(1'b1, occ_pkg::OFF_CMD, {24'h0, occ_pkg::CMD_CAL});
		k = 0;
		do begin
			@(posedge core_clk_in);
			k++;
			if (k == 3) check("cal_osc", hs_osc_en, 1'b1);
		end while (irq !== 1'b1 && k < 8000);
		apb(1'b0, occ_pkg::OFF_STAT, 32'h0);
		check("cal_flag", rd, 32'h0000_0002);
		apb(1'b0, occ_pkg::OFF_RES, 32'h0);
		q = rd / occ_pkg::HS_RATIO_Q16;
		check("cal_frac", rd % occ_pkg::HS_RATIO_Q16, 0);
		check("cal_span", q >= ((2 << c) - 1) * 305 - 3
			&& q <= (2 << c) * 306 + 3, 1'b1);
		$display("test calibration done");
		report_and_stop();
	end
endmodule
